//--- logic/tcf_pkg.sv
// Shared constants and types for the torque command filter chain.
package tcf_pkg;
    // ==========================================================
    // Widths and sample format
    localparam int SAMPLE_W = 16;
    localparam int ACC_W = 24;
    localparam int SAMPLE_SHIFT = 8;
    localparam int FRAC = 14;
    localparam int FIFO_DEPTH = 16;
    localparam int NSET = 15;
    localparam logic signed [47:0] ACC_MAXV = 48'sh0000_007f_ffff;
    localparam logic signed [47:0] ACC_MINV = 48'shffff_ff80_0000;
    localparam logic signed [23:0] ACC_MAX = 24'sh7fffff;
    localparam logic signed [23:0] ACC_MIN = 24'sh800000;
    // ==========================================================
    // Register map, word index is byte address divided by four
    localparam logic [4:0] IDX_TC = 5'h00;
    localparam logic [4:0] IDX_L2_CUT = 5'h01;
    localparam logic [4:0] IDX_L2_Q = 5'h02;
    localparam logic [4:0] IDX_NOTCH0 = 5'h03;
    localparam logic [4:0] IDX_CTRL = 5'h0f;
    localparam logic [4:0] IDX_STAT = 5'h10;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam logic [1:0] CTRL_DEF = 2'h1;
    localparam int STAT_BUSY_BIT = 5;
    localparam int STAT_LVL_LSB = 8;
    // ==========================================================
    // Setting kinds, ranges and reset values
    localparam logic [2:0] KIND_TC = 3'h0;
    localparam logic [2:0] KIND_CUT = 3'h1;
    localparam logic [2:0] KIND_L2Q = 3'h2;
    localparam logic [2:0] KIND_NF = 3'h3;
    localparam logic [2:0] KIND_NQ = 3'h4;
    localparam logic [2:0] KIND_ND = 3'h5;
    localparam logic [15:0] TC_MAX = 16'hffff;
    localparam logic [15:0] TC_DEF = 16'h0064;
    localparam logic [15:0] CUT_MIN = 16'h0064;
    localparam logic [15:0] FREQ_MAX = 16'h1388;
    localparam logic [15:0] L2Q_MIN = 16'h0032;
    localparam logic [15:0] L2Q_MAX = 16'h0064;
    localparam logic [15:0] NF_MIN = 16'h0032;
    localparam logic [15:0] NQ_MIN = 16'h0032;
    localparam logic [15:0] NQ_MAX = 16'h03e8;
    localparam logic [15:0] NQ_DEF = 16'h02bc;
    localparam logic [15:0] ND_MAX = 16'h03e8;
    localparam logic [15:0] ZERO16 = 16'h0000;
    // ==========================================================
    // Timing and coefficient scaling
    localparam int CLK_HZ = 20_000_000;
    localparam int FS_HZ = 40_000;
    localparam int SAMPLE_PERIOD_NS = 1_000_000_000 / FS_HZ;
    localparam int TC_UNIT_NS = 10_000;
    localparam logic [31:0] TS_X2 = 32'(2 * SAMPLE_PERIOD_NS / TC_UNIT_NS);
    localparam logic [31:0] ONE_Q14 = 32'h0000_4000;
    localparam logic [31:0] K_FREQ = 32'(int'(2.0 * 3.14159265 * 16384.0 * 4096.0 / FS_HZ));
    localparam logic [31:0] Q_SCALE = 32'(16384 * 100);
    localparam logic [31:0] DEPTH_FULL = 32'h0000_03e8;
    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LPF1 = 3'b001,
        ST_LPF2 = 3'b011,
        ST_NOTCH = 3'b010,
        ST_OUT = 3'b110
    } tcf_state_e;
    typedef struct packed {
        logic [15:0] lo;
        logic [15:0] hi;
        logic [15:0] def;
    } tcf_lim_s;
    typedef struct packed {
        logic [16:0] a1;
        logic [4:0][16:0] f;
        logic [4:0][16:0] qi;
        logic [3:0][16:0] dk;
        logic [4:0] byp;
    } tcf_coef_s;
endpackage

//--- logic/tcf_fifo.sv
// Sample FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module tcf_fifo #(
    parameter int W = 16,
    parameter int D = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [W-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [W-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [$clog2(D):0] level_o
);
    localparam int AW = $clog2(D);
    // ==========================================================
    // Storage and pointers
    logic [D-1:0][W-1:0] mem_q;
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic rdy_q;
    logic vld_q;
    wire push = in_valid_i & rdy_q & ce_i;
    wire pop = out_ready_i & vld_q & ce_i;
    wire [AW:0] cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
            vld_q <= 1'b0;
        end else if (ce_i) begin
            wr_q <= wr_q + AW'(push);
            rd_q <= rd_q + AW'(pop);
            cnt_q <= cnt_d;
            rdy_q <= cnt_d != (AW + 1)'(D);
            vld_q <= cnt_d != '0;
        end
    end

    // The array has no reset; only entries that have been written are ever read.
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    assign in_ready_o = rdy_q;
    assign out_valid_o = vld_q;
    assign out_data_o = mem_q[rd_q];
    assign level_o = cnt_q;
endmodule

//--- logic/tcf_filter_chain.sv
// Torque command filter chain: register file, sample FIFO and serial filter engine.
`timescale 1ns/1ps
//
// Notes on behaviour
// - Stages run in series: LPF1, LPF2, four notches.
// - Second low-pass bypassed at 5000 Hz cutoff.
// - Third notch bypassed at 5000 Hz.
// - Fourth notch bypassed at 5000 Hz.
// - Time constant 0 to 655.35 ms, default 1.00.
// - Low-pass cutoff 100 to 5000 Hz, default 5000.
// - Low-pass Q 0.50 to 1.00, default 1.00.
// - Notch set by frequency, width and depth.
// - Notch frequency 50 to 5000 Hz, default 5000.
// - Notch Q 0.50 to 10.00, default 7.00.
// - Notch depth 0 to 1, default 0.
module tcf_filter_chain import tcf_pkg::*; (
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [15:0] SAMPLE_I,
    input wire logic SAMPLE_VALID_I,
    output logic SAMPLE_READY_O,
    output logic [15:0] FILT_O,
    output logic FILT_VALID_O,
    input wire logic FILT_READY_I
);
    // ==========================================================
    // Arithmetic helpers
    function automatic logic signed [23:0] sat_acc(input logic signed [47:0] v);
        if (v > ACC_MAXV) begin
            return ACC_MAX;
        end else if (v < ACC_MINV) begin
            return ACC_MIN;
        end
        return v[23:0];
    endfunction

    function automatic logic signed [23:0] mulq(input logic signed [23:0] a, input logic [16:0] c);
        logic signed [47:0] p;
        p = 48'(a) * 48'(signed'({1'b0, c}));
        return sat_acc(p >>> FRAC);
    endfunction

    function automatic logic signed [23:0] sadd(input logic signed [23:0] a, input logic signed [23:0] b);
        return sat_acc(48'(a) + 48'(b));
    endfunction

    function automatic logic signed [23:0] ssub(input logic signed [23:0] a, input logic signed [23:0] b);
        return sat_acc(48'(a) - 48'(b));
    endfunction

    // Small-angle tuning word; exact enough below a quarter of the sample rate.
    function automatic logic [16:0] freq_coef(input logic [15:0] f);
        logic [31:0] p;
        p = 32'(f) * K_FREQ;
        return 17'(p >> 12);
    endfunction

    function automatic logic [16:0] qinv(input logic [15:0] q);
        logic [31:0] r;
        r = (q == ZERO16) ? ONE_Q14 : Q_SCALE / 32'(q);
        return 17'(r);
    endfunction

    function automatic logic [2:0] kind_of(input logic [4:0] idx);
        logic [4:0] rel;
        rel = idx - IDX_NOTCH0;
        if (idx == IDX_TC) begin
            return KIND_TC;
        end else if (idx == IDX_L2_CUT) begin
            return KIND_CUT;
        end else if (idx == IDX_L2_Q) begin
            return KIND_L2Q;
        end
        return KIND_NF + 3'(rel % 5'h03);
    endfunction

    function automatic tcf_lim_s lim_of(input logic [4:0] idx);
        case (kind_of(idx))
            KIND_TC: return '{ZERO16, TC_MAX, TC_DEF};
            KIND_CUT: return '{CUT_MIN, FREQ_MAX, FREQ_MAX};
            KIND_L2Q: return '{L2Q_MIN, L2Q_MAX, L2Q_MAX};
            KIND_NF: return '{NF_MIN, FREQ_MAX, FREQ_MAX};
            KIND_NQ: return '{NQ_MIN, NQ_MAX, NQ_DEF};
            KIND_ND: return '{ZERO16, ND_MAX, ZERO16};
            default: return '{ZERO16, TC_MAX, ZERO16};
        endcase
    endfunction

    function automatic logic [15:0] def_of(input logic [4:0] idx);
        tcf_lim_s l;
        l = lim_of(idx);
        return l.def;
    endfunction

    // Out-of-range writes are clamped rather than refused so the stage never sees a bad value.
    function automatic logic [15:0] clamp(input logic [4:0] idx, input logic [15:0] v);
        tcf_lim_s l;
        l = lim_of(idx);
        if (v < l.lo) begin
            return l.lo;
        end else if (v > l.hi) begin
            return l.hi;
        end
        return v;
    endfunction

    // ==========================================================
    // Wishbone slave and register file
    logic [NSET-1:0][15:0] set_q;
    logic [1:0] ctrl_q;
    logic ack_q;
    logic [31:0] rdat_q;
    tcf_state_e state_q;
    tcf_coef_s coef_q;
    logic [4:0] fifo_lvl;

    wire req = WB_CYC_I & WB_STB_I & ~ack_q & CE_I;
    wire [4:0] widx = WB_ADR_I[6:2];
    wire word_ok = (WB_ADR_I[1:0] == 2'h0) & ~WB_ADR_I[7];
    wire wr_set = req & WB_WE_I & word_ok & (widx < 5'(NSET));
    wire wr_ctrl = req & WB_WE_I & word_ok & (widx == IDX_CTRL) & WB_SEL_I[0];
    wire [15:0] old_set = set_q[widx[3:0]];
    wire [15:0] merged = {WB_SEL_I[1] ? WB_DAT_I[15:8] : old_set[15:8], WB_SEL_I[0] ? WB_DAT_I[7:0] : old_set[7:0]};
    wire clr_done = CE_I & (state_q == ST_IDLE) & ctrl_q[CTRL_CLR_BIT];
    wire [31:0] stat_word = {19'h0, fifo_lvl, 2'h0, state_q != ST_IDLE, coef_q.byp};
    wire [31:0] rd_word = (!word_ok) ? 32'h0 :
                          (widx < 5'(NSET)) ? {16'h0, set_q[widx[3:0]]} :
                          (widx == IDX_CTRL) ? {30'h0, ctrl_q} :
                          (widx == IDX_STAT) ? stat_word : 32'h0;

    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0;
        end else if (CE_I) begin
            ack_q <= WB_CYC_I & WB_STB_I & ~ack_q;
            rdat_q <= req ? rd_word : 32'h0;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            for (int i = 0; i < NSET; i++) begin
                set_q[i] <= def_of(5'(i));
            end
        end else if (wr_set) begin
            set_q[widx[3:0]] <= clamp(widx, merged);
        end
    end

    // A software write to the clear bit wins over the hardware clearing it.
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            ctrl_q <= CTRL_DEF;
        end else if (wr_ctrl) begin
            ctrl_q <= WB_DAT_I[1:0];
        end else if (clr_done) begin
            ctrl_q[CTRL_CLR_BIT] <= 1'b0;
        end
    end

    // ==========================================================
    // Coefficients derived from the settings
    tcf_coef_s coef_d;
    always_comb begin
        logic [4:0] fi;
        fi = 5'h0;
        coef_d = '0;
        coef_d.a1 = 17'((ONE_Q14 * TS_X2) / (32'(set_q[IDX_TC]) * 32'h2 + TS_X2));
        coef_d.f[0] = freq_coef(set_q[IDX_L2_CUT]);
        coef_d.qi[0] = qinv(set_q[IDX_L2_Q]);
        coef_d.byp[0] = set_q[IDX_L2_CUT] == FREQ_MAX;
        for (int k = 0; k < 4; k++) begin
            fi = IDX_NOTCH0 + 5'(3 * k);
            coef_d.f[k + 1] = freq_coef(set_q[fi[3:0]]);
            coef_d.qi[k + 1] = qinv(set_q[fi[3:0] + 4'h1]);
            coef_d.dk[k] = 17'(((DEPTH_FULL - 32'(set_q[fi[3:0] + 4'h2])) * ONE_Q14) / DEPTH_FULL);
            coef_d.byp[k + 1] = set_q[fi[3:0]] == FREQ_MAX;
        end
    end

    // ==========================================================
    // Input FIFO
    logic [15:0] fifo_data;
    logic fifo_valid;
    logic outv_q;
    wire fifo_pop = (state_q == ST_IDLE) & ~ctrl_q[CTRL_CLR_BIT] & ~outv_q;

    tcf_fifo #(
        .W(SAMPLE_W),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(CLOCK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .in_data_i(SAMPLE_I),
        .in_valid_i(SAMPLE_VALID_I),
        .in_ready_o(SAMPLE_READY_O),
        .out_data_o(fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .level_o(fifo_lvl)
    );

    // ==========================================================
    // Serial filter engine, one stage per clock
    logic [1:0] n_q;
    logic signed [23:0] x_q;
    logic signed [23:0] y1_q;
    logic signed [4:0][23:0] lp_q;
    logic signed [4:0][23:0] bp_q;
    logic [15:0] out_q;

    wire [2:0] s_idx = (state_q == ST_LPF2) ? 3'h0 : {1'b0, n_q} + 3'h1;
    wire signed [23:0] y1_n = sadd(y1_q, mulq(ssub(x_q, y1_q), coef_q.a1));
    wire signed [23:0] lp_c = lp_q[s_idx];
    wire signed [23:0] bp_c = bp_q[s_idx];
    wire signed [23:0] hp = ssub(ssub(x_q, lp_c), mulq(bp_c, coef_q.qi[s_idx]));
    wire signed [23:0] bp_n = sadd(bp_c, mulq(hp, coef_q.f[s_idx]));
    wire signed [23:0] lp_n = sadd(lp_c, mulq(bp_n, coef_q.f[s_idx]));
    wire signed [23:0] band = mulq(bp_n, coef_q.qi[s_idx]);
    wire signed [23:0] notch_y = ssub(x_q, mulq(band, coef_q.dk[n_q]));
    wire stage_byp = coef_q.byp[s_idx];

    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            state_q <= ST_IDLE;
            n_q <= 2'h0;
            x_q <= '0;
            coef_q <= '0;
        end else if (CE_I) begin
            case (state_q)
                ST_IDLE: begin
                    if (fifo_pop && fifo_valid) begin
                        x_q <= {SAMPLE_W'(fifo_data), 8'h00};
                        coef_q <= coef_d;
                        state_q <= ctrl_q[CTRL_EN_BIT] ? ST_LPF1 : ST_OUT;
                    end
                end
                ST_LPF1: begin
                    x_q <= y1_n;
                    state_q <= ST_LPF2;
                end
                ST_LPF2: begin
                    x_q <= stage_byp ? x_q : lp_n;
                    n_q <= 2'h0;
                    state_q <= ST_NOTCH;
                end
                ST_NOTCH: begin
                    x_q <= stage_byp ? x_q : notch_y;
                    n_q <= n_q + 2'h1;
                    state_q <= (n_q == 2'h3) ? ST_OUT : ST_NOTCH;
                end
                ST_OUT: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // A bypassed stage keeps zero state, so re-enabling it starts without a stale transient.
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I || (CE_I && clr_done)) begin
            y1_q <= '0;
            lp_q <= '0;
            bp_q <= '0;
        end else if (CE_I && state_q == ST_LPF1) begin
            y1_q <= y1_n;
        end else if (CE_I && (state_q == ST_LPF2 || state_q == ST_NOTCH)) begin
            lp_q[s_idx] <= stage_byp ? 24'sh0 : lp_n;
            bp_q[s_idx] <= stage_byp ? 24'sh0 : bp_n;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            out_q <= 16'h0;
            outv_q <= 1'b0;
        end else if (CE_I) begin
            if (state_q == ST_OUT) begin
                out_q <= x_q[23:SAMPLE_SHIFT];
                outv_q <= 1'b1;
            end else if (FILT_READY_I) begin
                outv_q <= 1'b0;
            end
        end
    end

    assign WB_DAT_O = rdat_q;
    assign WB_ACK_O = ack_q;
    assign FILT_O = out_q;
    assign FILT_VALID_O = outv_q;

    // ==========================================================
    // Checks
    chk_chain_order: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (state_q == ST_LPF1 && CE_I) |=> (state_q == ST_LPF2 && x_q == $past(y1_n)))
        else $error("first stage did not feed the second");
    chk_notch_last: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (state_q == ST_NOTCH && n_q == 2'h3 && CE_I) |=> state_q == ST_OUT)
        else $error("chain did not end after the fourth notch");
    chk_lpf2_bypass: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (state_q == ST_LPF2 && CE_I && coef_q.f[0] == freq_coef(FREQ_MAX)) |=> $stable(x_q))
        else $error("second low-pass not bypassed at its top cutoff");
    chk_notch_c_bypass: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (state_q == ST_NOTCH && n_q == 2'h2 && CE_I && coef_q.byp[3]) |=> x_q == $past(x_q))
        else $error("third notch not bypassed");
    chk_notch_d_bypass: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (state_q == ST_NOTCH && n_q == 2'h3 && CE_I && coef_q.byp[4]) |=> x_q == $past(x_q))
        else $error("fourth notch not bypassed");
    chk_reset_defaults: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        $rose(RST_N_I) |-> (set_q[IDX_TC] == TC_DEF && set_q[IDX_L2_CUT] == FREQ_MAX
            && set_q[IDX_NOTCH0 + 5'h1] == NQ_DEF && set_q[IDX_NOTCH0 + 5'h2] == ZERO16))
        else $error("settings did not start at their defaults");
    chk_lpf2_q_range: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        set_q[IDX_L2_Q] >= L2Q_MIN && set_q[IDX_L2_Q] <= L2Q_MAX)
        else $error("second low-pass Q out of range");
    chk_notch_freq_range: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (wr_set && kind_of(widx) == KIND_NF) |=> set_q[$past(widx[3:0])] >= NF_MIN
            && set_q[$past(widx[3:0])] <= FREQ_MAX)
        else $error("notch frequency stored out of range");
    chk_depth_unity: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (state_q == ST_NOTCH && CE_I && coef_q.dk[n_q] == 17'h0) |=> x_q == $past(x_q))
        else $error("full depth setting still altered the sample");
    chk_coef_hold: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (state_q != ST_IDLE) |=> $stable(coef_q))
        else $error("coefficients changed inside a sample");
    chk_ack_single: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
        (ack_q && CE_I) |=> !ack_q)
        else $error("acknowledge held for more than one cycle");
endmodule

//--- verif/tcf_far_side.sv
// Far-side model: speed loop command source and current loop sink.
`timescale 1ns/1ps
module tcf_far_side (
    input wire logic clk_i,
    input wire logic stall_i,
    input wire logic ready_i,
    input wire logic [15:0] filt_i,
    input wire logic filt_valid_i,
    output logic [15:0] sample_o,
    output logic sample_valid_o,
    output logic filt_ready_o
);
    logic [15:0] got[$];
    initial begin
        sample_o = 16'h0000;
        sample_valid_o = 1'b0;
        filt_ready_o = 1'b0;
    end
    // ==========================================================
    // Source
    // The line is inverted after a transfer so a stale value never passes for a fresh one.
    task automatic send(input logic [15:0] v);
        @(posedge clk_i);
        sample_o <= v;
        sample_valid_o <= 1'b1;
        do @(posedge clk_i); while (ready_i !== 1'b1);
        sample_valid_o <= 1'b0;
        sample_o <= ~v;
    endtask
    // ==========================================================
    // Sink, stalls whenever the bench asks for back-pressure
    always @(posedge clk_i) begin
        if (filt_valid_i === 1'b1 && filt_ready_o === 1'b1) begin
            got.push_back(filt_i);
        end
        filt_ready_o <= !stall_i;
    end
endmodule

//--- verif/tcf_filter_chain_bench.sv
// Self-checking bench for the torque command filter chain.
`timescale 1ns/1ps
module tcf_filter_chain_bench import tcf_pkg::*; ();
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic [15:0] smp;
    logic svalid;
    logic sready;
    logic [15:0] filt;
    logic fvalid;
    logic fready;
    logic stall = 1'b0;
    logic clk_en = 1'b1;
    logic [3:0] sel = 4'hf;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] q;
    logic [7:0] fa[5] = '{8'h04, 8'h0c, 8'h18, 8'h24, 8'h30};
    logic [7:0] ra[11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h80};
    logic [15:0] re[11] = '{TC_DEF, FREQ_MAX, L2Q_MAX, FREQ_MAX, NQ_DEF, ZERO16, FREQ_MAX, NQ_DEF, ZERO16,
                            16'h0001, ZERO16};
    logic [7:0] ca[10] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h08, 8'h08, 8'h18, 8'h1c, 8'h1c, 8'h20};
    logic [15:0] cw[10] = '{16'hffff, 16'h0000, 16'h0010, 16'h2000, 16'h0000, 16'h00ff, 16'h0001, 16'hffff,
                            16'h0000, 16'hffff};
    logic [15:0] ce[10] = '{16'hffff, 16'h0000, 16'h0064, 16'h1388, 16'h0032, 16'h0064, 16'h0032, 16'h03e8,
                            16'h0032, 16'h03e8};

    tcf_filter_chain DUT (.CLOCK_I(clk), .RST_N_I(rst_n), .CE_I(clk_en), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .SAMPLE_I(smp), .SAMPLE_VALID_I(svalid), .SAMPLE_READY_O(sready), .FILT_O(filt),
        .FILT_VALID_O(fvalid), .FILT_READY_I(fready));
    tcf_far_side P (.clk_i(clk), .stall_i(stall), .ready_i(sready), .filt_i(filt), .filt_valid_i(fvalid),
        .sample_o(smp), .sample_valid_o(svalid), .filt_ready_o(fready));

    initial begin
        forever #25 clk = ~clk;
    end
    // ==========================================================
    // Shared tasks
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_smp(input string nm, input logic signed [15:0] e, input logic signed [15:0] g, input int t);
        tests_run++;
        if ($isunknown(g) || g > e + t || g < e - t) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Classic single cycle; the ack is sampled on the edge, before that edge's updates land.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    task automatic wait_out(input int n);
        for (int k = 0; k < 20000 && P.got.size() < n; k++) @(posedge clk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic sc_defaults();
        for (int i = 0; i < 11; i++) begin
            wb(1'b0, ra[i], 32'h0);
            chk_reg("reset value", {16'h0000, re[i]}, q);
        end
    endtask
    task automatic sc_clamp();
        for (int i = 0; i < 10; i++) begin
            wb(1'b1, ca[i], {16'hffff, cw[i]});
            wb(1'b0, ca[i], 32'h0);
            chk_reg("clamped setting", {16'h0000, ce[i]}, q);
        end
        sel <= 4'h1;
        wb(1'b1, 8'h00, 32'h0000_ab34);
        sel <= 4'hf;
        wb(1'b0, 8'h00, 32'h0);
        chk_reg("byte lane merge", 32'h0034, q);
        wb(1'b1, 8'h80, 32'h1234);
        wb(1'b0, 8'h80, 32'h0);
        chk_reg("unmapped", 32'h0, q);
    endtask
    task automatic sc_bypass();
        for (int i = 0; i < 5; i++) begin
            P.got.delete();
            wb(1'b1, fa[i], 32'h1387);
            P.send(16'h0100);
            wait_out(1);
            wb(1'b0, 8'h40, 32'h0);
            chk_reg("bypass flags", 32'(5'h1f & ~(5'h01 << i)), {27'h0, q[4:0]});
            wb(1'b1, fa[i], {16'h0000, FREQ_MAX});
        end
    endtask
    // The sink stalls so the FIFO has to fill and refuse before it drains in order.
    task automatic sc_fifo();
        int n;
        n = 0;
        wb(1'b1, 8'h3c, 32'h0);
        P.got.delete();
        stall <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            @(negedge clk);
            if (sready !== 1'b1) break;
            P.send(16'(i * 16'h0123));
            n++;
        end
        wb(1'b0, 8'h40, 32'h0);
        chk_reg("fifo level", 32'h10, {27'h0, q[12:8]});
        chk_reg("ready when full", 32'h0, {31'h0, sready});
        stall <= 1'b0;
        wait_out(n);
        for (int i = 0; i < n; i++) begin
            chk_smp("passed sample", 16'(i * 16'h0123), P.got[i], 0);
        end
    endtask
    task automatic sc_dc();
        wb(1'b1, 8'h3c, 32'h3);
        wb(1'b1, 8'h0c, 32'h03e8);
        wb(1'b1, 8'h14, 32'h03e8);
        P.got.delete();
        repeat (300) P.send(16'h1000);
        wait_out(300);
        chk_smp("first filtered", 16'h0064, P.got[0], 2);
        chk_smp("settled dc", 16'h1000, P.got[299], 16);
        wb(1'b1, 8'h00, 32'h0);
        P.got.delete();
        repeat (8) P.send(16'h0800);
        wait_out(8);
        chk_smp("zero time constant", 16'h0800, P.got[7], 4);
    endtask
    // Clock enable low must hold off both the bus answer and the sample intake.
    task automatic sc_freeze();
        P.got.delete();
        @(posedge clk);
        clk_en <= 1'b0;
        fork
            wb(1'b0, 8'h3c, 32'h0);
            P.send(16'h0400);
            begin
                repeat (6) @(posedge clk);
                chk_reg("ack while frozen", 32'h0, {31'h0, ack});
                clk_en <= 1'b1;
            end
        join
        chk_reg("read after freeze", 32'h1, q);
        repeat (12) @(posedge clk);
        chk_reg("sample taken while frozen", 32'h0, 32'(P.got.size()));
    endtask
    // ==========================================================
    // Main sequence and watchdog
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        do_reset();
        sc_defaults();
        sc_clamp();
        do_reset();
        sc_bypass();
        sc_fifo();
        sc_dc();
        sc_freeze();
        report_and_stop();
    end
endmodule
